/* rtl/vafe_coast.sv */
// line counting coast window around vertical sync
`timescale 1ns/1ps
module vafe_coast
  import vafe_pkg::*;
(
  input  wire logic   mclk,
  input  wire logic   reset,
  input  wire logic   ce,
  input  wire logic   line_pulse,
  input  wire logic   vsync,
  vafe_coast_if.seq   cif
);
  typedef struct packed {
    logic [LINE_W-1:0] line_cnt;
    logic [LINE_W-1:0] frame_lines;
    logic [7:0]        post_cnt;
    logic              vs_prev;
    logic              coast;
  } vafe_coast_s;

  vafe_coast_s st_reg;
  vafe_coast_s st_next;
  logic [LINE_W:0] lines_ahead;

  // lines counted from the last vsync plus the pre-coast margin
  assign lines_ahead = {1'b0, st_reg.line_cnt} + {{(LINE_W-7){1'b0}}, cif.pre_lines};

  // frame length is learned from the previous frame, so the first frame has no pre-coast
  always_comb
  begin
    st_next = st_reg;
    st_next.vs_prev = vsync;
    if (vsync && !st_reg.vs_prev)
    begin
      st_next.frame_lines = st_reg.line_cnt;
      st_next.line_cnt = '0;
    end
    else if (line_pulse && !vsync)
    begin
      st_next.line_cnt = st_reg.line_cnt + 1'b1;
    end
    if (!vsync && st_reg.vs_prev)
    begin
      st_next.post_cnt = cif.post_lines;
    end
    else if (line_pulse && st_reg.post_cnt != 8'h00)
    begin
      st_next.post_cnt = st_reg.post_cnt - 1'b1;
    end
    st_next.coast = vsync || st_next.post_cnt != 8'h00 ||
      (st_reg.frame_lines != '0 && lines_ahead >= {1'b0, st_reg.frame_lines});
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      st_reg <= '0;
    else if (ce)
      st_reg <= st_next;
  end

  assign cif.coast = st_reg.coast;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  AST_POST_COAST: assert property (ce && !vsync && st_reg.vs_prev && cif.post_lines != 8'h00 |=> cif.coast)
    else $error("coast not held after vsync end");
  AST_VSYNC_COAST: assert property (ce && vsync |=> cif.coast)
    else $error("coast missing during vsync");
  CVR_POST: cover property (ce && !vsync && st_reg.vs_prev ##1 cif.coast);
endmodule

/* rtl/vafe_coast_if.sv */
// coast line counts from the register bank and the coast state back
`timescale 1ns/1ps
interface vafe_coast_if;
  logic [7:0] pre_lines;
  logic [7:0] post_lines;
  logic       coast;
  modport ctl (output pre_lines, output post_lines, input coast);
  modport seq (input pre_lines, input post_lines, output coast);
endinterface

/* rtl/vafe_pkg.sv */
// register map, reset values and field positions of the offset and pll register slice
package vafe_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_RED_OFF    = 6'h09;
  localparam logic [5:0] IDX_GREEN_OFF  = 6'h0A;
  localparam logic [5:0] IDX_BLUE_OFF   = 6'h0B;
  localparam logic [5:0] IDX_DAC_CFG    = 6'h0C;
  localparam logic [5:0] IDX_BANDWIDTH  = 6'h0D;
  localparam logic [5:0] IDX_LT_HIGH    = 6'h0E;
  localparam logic [5:0] IDX_LT_LOW     = 6'h0F;
  localparam logic [5:0] IDX_PHASE      = 6'h10;
  localparam logic [5:0] IDX_COAST_PRE  = 6'h11;
  localparam logic [5:0] IDX_COAST_POST = 6'h12;
  localparam logic [5:0] IDX_PLL_MISC   = 6'h13;
  // values after reset
  localparam logic [7:0] RST_OFFSET     = 8'h80;
  localparam logic [7:0] RST_DAC_CFG    = 8'h00;
  localparam logic [7:0] RST_BANDWIDTH  = 8'h2E;
  localparam logic [5:0] RST_LT_HIGH    = 6'h03;
  localparam logic [7:0] RST_LT_LOW     = 8'h20;
  localparam logic [5:0] RST_PHASE      = 6'h00;
  localparam logic [7:0] RST_COAST      = 8'h04;
  localparam logic [7:0] RST_PLL_MISC   = 8'h04;
  localparam logic [9:0] DAC_MID_SCALE  = 10'h200;
  // field positions
  localparam int DAC_RANGE_BIT  = 0;
  localparam int DAC_LSB_BASE   = 2;
  localparam int BW_CUTOFF_LSB  = 1;
  localparam int BW_PEAK_LSB    = 4;
  localparam int MISC_EDGE_BIT0 = 0;
  localparam int MISC_CLKINV    = 3;
  // phase step in thousandths of a degree
  localparam int PHASE_STEP_MDEG = 5625;
  localparam int NUM_CH          = 3;
  localparam int LINE_W          = 12;
endpackage

/* rtl/vafe_regs.sv */
// offset, bandwidth and pll control registers behind an avalon-mm slave
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module vafe_regs
  import vafe_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 reset,
  input  wire logic                 ce,
  input  wire logic [7:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic                 auto_black_level_comp,
  input  wire logic                 ext_clamp_sel,
  input  wire logic                 clamp_pulse,
  input  wire logic                 first_hsync_input,
  input  wire logic                 second_hsync_input,
  input  wire logic                 hsync_select,
  input  wire logic                 vsync,
  input  wire logic                 clock_invert_pin,
  output logic [NUM_CH*8-1:0]       digital_offset,
  output logic [NUM_CH*10-1:0]      offset_dac_code,
  output logic                      dac_range_quarter,
  output logic [2:0]                frontend_cutoff_code,
  output logic [3:0]                peaking_code,
  output logic [13:0]               pll_line_total,
  output logic [5:0]                sample_phase,
  output logic [1:0]                pll_lock_pulse,
  output logic                      pll_coast,
  output logic                      clock_invert_eff
);
  typedef struct packed {
    logic [NUM_CH-1:0][7:0] offset;
    logic [7:0]             dac_cfg;
    logic [7:0]             bandwidth;
    logic [5:0]             lt_high;
    logic [7:0]             lt_low;
    logic [5:0]             phase;
    logic [7:0]             coast_pre;
    logic [7:0]             coast_post;
    logic [7:0]             misc;
    logic [13:0]            lt_applied;
    logic [NUM_CH-1:0][9:0] dac_applied;
    logic [NUM_CH-1:0][7:0] dig;
    logic [1:0]             hs_prev;
    logic [1:0]             lock;
    logic                   clamp_prev;
    logic                   clkinv;
    logic                   ack;
    logic [31:0]            rdata;
  } vafe_regs_s;

  localparam vafe_regs_s ST_RESET = '{
    offset:      {NUM_CH{RST_OFFSET}},
    dac_cfg:     RST_DAC_CFG,
    bandwidth:   RST_BANDWIDTH,
    lt_high:     RST_LT_HIGH,
    lt_low:      RST_LT_LOW,
    phase:       RST_PHASE,
    coast_pre:   RST_COAST,
    coast_post:  RST_COAST,
    misc:        RST_PLL_MISC,
    lt_applied:  {RST_LT_HIGH, RST_LT_LOW},
    dac_applied: {NUM_CH{DAC_MID_SCALE}},
    dig:         '0,
    hs_prev:     2'h0,
    lock:        2'h0,
    clamp_prev:  1'b0,
    clkinv:      1'b0,
    ack:         1'b0,
    rdata:       32'h0000_0000
  };

  vafe_regs_s st_reg;
  vafe_regs_s st_next;

  logic                   req;
  logic                   wr_take;
  logic [5:0]             idx;
  logic                   aligned;
  logic [7:0]             wbyte;
  logic [1:0]             hs_in;
  logic [1:0]             lock_edge;
  logic                   clamp_rise;
  logic [NUM_CH-1:0][9:0] dac_target;

  vafe_coast_if cif ();

  // one wait cycle per access; the write lands on the edge where waitrequest is low
  assign req             = avs_read || avs_write;
  assign avs_waitrequest = req && !st_reg.ack;
  assign wr_take         = avs_write && st_reg.ack && ce;
  assign idx             = avs_address[7:2];
  assign aligned         = avs_address[1:0] == 2'b00;
  assign wbyte           = avs_writedata[7:0];
  assign hs_in           = {second_hsync_input, first_hsync_input};
  assign clamp_rise      = clamp_pulse && !st_reg.clamp_prev;

  // manual DAC code: register value over its two low bits
  generate
    for (genvar ch = 0; ch < NUM_CH; ch++)
    begin : g_dac
      assign dac_target[ch] = {st_reg.offset[ch],
        st_reg.dac_cfg[DAC_LSB_BASE+2*ch +: 2]};
    end
  endgenerate

  // lock edge per hsync input: trailing is the falling edge of an active high pulse
  generate
    for (genvar h = 0; h < 2; h++)
    begin : g_lock
      assign lock_edge[h] = st_reg.misc[MISC_EDGE_BIT0+h] ?
        (hs_in[h] && !st_reg.hs_prev[h]) : (!hs_in[h] && st_reg.hs_prev[h]);
    end
  endgenerate

  // read mux; unmapped or unaligned addresses read as zero
  function automatic logic [7:0] read_byte(input vafe_regs_s s, input logic [5:0] i);
    logic [7:0] v;
    v = 8'h00;
    unique case (i)
      IDX_RED_OFF:    v = s.offset[0];
      IDX_GREEN_OFF:  v = s.offset[1];
      IDX_BLUE_OFF:   v = s.offset[2];
      IDX_DAC_CFG:    v = s.dac_cfg;
      IDX_BANDWIDTH:  v = s.bandwidth;
      IDX_LT_HIGH:    v = {2'b00, s.lt_high};
      IDX_LT_LOW:     v = s.lt_low;
      IDX_PHASE:      v = {2'b00, s.phase};
      IDX_COAST_PRE:  v = s.coast_pre;
      IDX_COAST_POST: v = s.coast_post;
      IDX_PLL_MISC:   v = s.misc;
      default:        v = 8'h00;
    endcase
    return v;
  endfunction

  // next state: bus, register writes, then the derived control values
  always_comb
  begin
    st_next = st_reg;
    st_next.ack = req && !st_reg.ack;
    if (req && !st_reg.ack)
    begin
      st_next.rdata = {24'h00_0000, aligned ? read_byte(st_reg, idx) : 8'h00};
    end
    if (wr_take && aligned && avs_byteenable[0])
    begin
      unique case (idx)
        IDX_RED_OFF:    st_next.offset[0] = wbyte;
        IDX_GREEN_OFF:  st_next.offset[1] = wbyte;
        IDX_BLUE_OFF:   st_next.offset[2] = wbyte;
        IDX_DAC_CFG:    st_next.dac_cfg = wbyte;
        IDX_BANDWIDTH:  st_next.bandwidth = wbyte;
        IDX_LT_HIGH:    st_next.lt_high = wbyte[5:0];
        IDX_LT_LOW:
        begin
          st_next.lt_low = wbyte;
          st_next.lt_applied = {st_reg.lt_high, wbyte};
        end
        IDX_PHASE:      st_next.phase = wbyte[5:0];
        IDX_COAST_PRE:  st_next.coast_pre = wbyte;
        IDX_COAST_POST: st_next.coast_post = wbyte;
        IDX_PLL_MISC:   st_next.misc = wbyte;
        default:        st_next.rdata = st_reg.rdata;
      endcase
    end
    // digital offset is the register code less mid-scale, zero while manual
    for (int ch = 0; ch < NUM_CH; ch++)
    begin
      st_next.dig[ch] = auto_black_level_comp ?
        (st_reg.offset[ch] ^ RST_OFFSET) : 8'h00;
    end
    // external clamp holds the DAC until its leading edge, so no mid-line steps
    if (!auto_black_level_comp && (!ext_clamp_sel || clamp_rise))
    begin
      st_next.dac_applied = dac_target;
    end
    st_next.clamp_prev = clamp_pulse;
    st_next.hs_prev = hs_in;
    st_next.lock = lock_edge;
    st_next.clkinv = clock_invert_pin && !st_reg.misc[MISC_CLKINV];
  end

  // all state frozen while the clock enable is low
  always_ff @(posedge mclk)
  begin
    if (reset)
      st_reg <= ST_RESET;
    else if (ce)
      st_reg <= st_next;
  end

  // line pulses from the chosen hsync feed the coast window
  vafe_coast u_coast (
    .mclk       (mclk),
    .reset      (reset),
    .ce         (ce),
    .line_pulse (st_reg.lock[hsync_select]),
    .vsync      (vsync),
    .cif        (cif)
  );
  assign cif.pre_lines  = st_reg.coast_pre;
  assign cif.post_lines = st_reg.coast_post;

  // outputs straight from flip-flops
  assign avs_readdata         = st_reg.rdata;
  assign digital_offset       = st_reg.dig;
  assign offset_dac_code      = st_reg.dac_applied;
  assign dac_range_quarter    = st_reg.dac_cfg[DAC_RANGE_BIT];
  assign frontend_cutoff_code = st_reg.bandwidth[BW_CUTOFF_LSB +: 3];
  assign peaking_code         = st_reg.bandwidth[BW_PEAK_LSB +: 4];
  assign pll_line_total       = st_reg.lt_applied;
  assign sample_phase         = st_reg.phase;
  assign pll_lock_pulse       = st_reg.lock;
  assign pll_coast            = cif.coast;
  assign clock_invert_eff     = st_reg.clkinv;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  AST_WAIT_FIRST: assert property (req && !st_reg.ack |-> avs_waitrequest)
    else $error("first request cycle not stalled");
  AST_ANSWER_NEXT: assert property (ce && req && avs_waitrequest ##1 req |-> !avs_waitrequest)
    else $error("answer not given one cycle after request");
  AST_LT_HIGH_ONLY: assert property (wr_take && aligned && idx == IDX_LT_HIGH |=> $stable(pll_line_total))
    else $error("line total moved on high byte write");
  AST_LT_LOW_LOAD: assert property (wr_take && aligned && avs_byteenable[0] && idx == IDX_LT_LOW
    |=> pll_line_total == {$past(st_reg.lt_high), $past(wbyte)})
    else $error("line total not loaded from both bytes");
  AST_DIG_OFFSET: assert property (ce && auto_black_level_comp
    |=> digital_offset[7:0] == $past(st_reg.offset[0]) - 8'h80)
    else $error("digital offset not code minus mid-scale");
  AST_DAC_MANUAL: assert property (ce && !auto_black_level_comp && !ext_clamp_sel
    |=> offset_dac_code[29:20] == {$past(st_reg.offset[2]), $past(st_reg.dac_cfg[7:6])})
    else $error("manual DAC code not register over low bits");
  AST_DAC_CLAMP_HOLD: assert property (ext_clamp_sel && !clamp_rise |=> $stable(offset_dac_code))
    else $error("DAC changed without clamp leading edge");
  AST_CLKINV_OFF: assert property (ce && st_reg.misc[MISC_CLKINV] |=> !clock_invert_eff)
    else $error("clock invert pin not forced low");
  AST_LOCK_TRAIL: assert property (ce && !st_reg.misc[0] && st_reg.hs_prev[0] && !first_hsync_input
    |=> pll_lock_pulse[0])
    else $error("trailing edge lock pulse missing");
  AST_LOCK_LEAD2: assert property (ce && st_reg.misc[1] && !st_reg.hs_prev[1] && second_hsync_input
    |=> pll_lock_pulse[1])
    else $error("leading edge lock pulse missing");

  CVR_LT_LOAD: cover property (wr_take && idx == IDX_LT_LOW ##1 pll_line_total >= 14'h0200);
  CVR_CLAMP_LOAD: cover property (ext_clamp_sel && clamp_rise && !auto_black_level_comp ##1 $changed(offset_dac_code));
  CVR_READ: cover property (avs_read && avs_waitrequest ##1 avs_read && !avs_waitrequest);
  CVR_COAST: cover property ($rose(pll_coast));
endmodule

/* testbench/tb.sv */
// self-checking bench for the offset and pll control register slice
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
  begin n_checks++; if ((gt) !== (ex)) begin n_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, gt); end end
module tb;
  import vafe_pkg::*;
  logic        mclk, reset, ce, avs_read, avs_write, avs_waitrequest;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic        auto_black_level_comp, ext_clamp_sel, clamp_pulse, first_hsync_input;
  logic        second_hsync_input, hsync_select, vsync, clock_invert_pin;
  logic [23:0] digital_offset;
  logic [29:0] offset_dac_code;
  logic        dac_range_quarter, pll_coast, clock_invert_eff;
  logic [2:0]  frontend_cutoff_code;
  logic [3:0]  peaking_code;
  logic [13:0] pll_line_total;
  logic [5:0]  sample_phase;
  logic [1:0]  pll_lock_pulse;
  int          n_errors, n_checks;

  vafe_regs i_vafe_regs (.mclk(mclk), .reset(reset), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .auto_black_level_comp(auto_black_level_comp), .ext_clamp_sel(ext_clamp_sel),
    .clamp_pulse(clamp_pulse), .first_hsync_input(first_hsync_input),
    .second_hsync_input(second_hsync_input), .hsync_select(hsync_select), .vsync(vsync),
    .clock_invert_pin(clock_invert_pin), .digital_offset(digital_offset),
    .offset_dac_code(offset_dac_code), .dac_range_quarter(dac_range_quarter),
    .frontend_cutoff_code(frontend_cutoff_code), .peaking_code(peaking_code),
    .pll_line_total(pll_line_total), .sample_phase(sample_phase), .pll_lock_pulse(pll_lock_pulse),
    .pll_coast(pll_coast), .clock_invert_eff(clock_invert_eff));

  // 20 mhz clock
  always #25 mclk = ~mclk;

  task automatic give_verdict;
    if (n_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one avalon access; request launched after an edge, held to the edge where waitrequest is low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= {24'h000000, d};
    avs_write     <= wr;
    avs_read      <= !wr;
    // waitrequest only moves at rising edges, so its mid-cycle value is the one the next edge samples
    do
    begin
      @(negedge mclk);
    end while (avs_waitrequest !== 1'b0);
    // taking edge: the write commits here and read data is taken here; only the watchdog ends a hang
    @(posedge mclk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] ex);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    `CHK("readdata", {24'h000000, ex}, q)
  endtask

  // derived outputs lag the register by one edge; four cycles later they are settled
  task automatic settle;
    repeat (4) @(negedge mclk);
  endtask

  // reset values, then every register written and read back, then the decoded outputs
  task automatic t_regs;
    logic [7:0] adr [11] = '{8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38, 8'h3C, 8'h40, 8'h44, 8'h48, 8'h4C};
    logic [7:0] rst [11] = '{8'h80, 8'h80, 8'h80, 8'h00, 8'h2E, 8'h03, 8'h20, 8'h00, 8'h04, 8'h04, 8'h04};
    logic [7:0] wv  [11] = '{8'h5A, 8'hC3, 8'h3C, 8'hE5, 8'h1D, 8'hEA, 8'h55, 8'hC7, 8'h81, 8'h10, 8'h0B};
    logic [7:0] rb  [11] = '{8'h5A, 8'hC3, 8'h3C, 8'hE5, 8'h1D, 8'h2A, 8'h55, 8'h07, 8'h81, 8'h10, 8'h0B};
    settle();
    `CHK("dac_code", {3{10'h200}}, offset_dac_code)
    `CHK("line_total", 14'h0320, pll_line_total)
    `CHK("cutoff", 3'b111, frontend_cutoff_code)
    `CHK("peaking", 4'h2, peaking_code)
    `CHK("coast", 1'b0, pll_coast)
    for (int i = 0; i < 11; i++)
      rd_chk(adr[i], rst[i]);
    rd_chk(8'h50, 8'h00);
    for (int i = 0; i < 11; i++)
      wr8(adr[i], wv[i]);
    for (int i = 0; i < 11; i++)
      rd_chk(adr[i], rb[i]);
    settle();
    `CHK("cutoff", 3'b110, frontend_cutoff_code)
    `CHK("peaking", 4'h1, peaking_code)
    `CHK("phase", 6'h07, sample_phase)
    `CHK("range", 1'b1, dac_range_quarter)
    `CHK("line_total", 14'h2A55, pll_line_total)
  endtask

  // high byte alone must not reach the pll
  task automatic t_line_total;
    wr8(8'h38, 8'h05);
    settle();
    `CHK("line_total", 14'h2A55, pll_line_total)
    wr8(8'h3C, 8'h10);
    settle();
    `CHK("line_total", 14'h0510, pll_line_total)
  endtask

  // extremes of the offset code in both compensation modes
  task automatic t_offsets;
    wr8(8'h24, 8'h00);
    wr8(8'h28, 8'h80);
    wr8(8'h2C, 8'hFF);
    wr8(8'h30, 8'hE4);
    settle();
    `CHK("dac_code", {10'h3FF, 10'h202, 10'h001}, offset_dac_code)
    `CHK("digital_offset", 24'h000000, digital_offset)
    `CHK("range", 1'b0, dac_range_quarter)
    @(posedge mclk);
    auto_black_level_comp <= 1'b1;
    settle();
    `CHK("digital_offset", {8'h7F, 8'h00, 8'h80}, digital_offset)
    wr8(8'h24, 8'h81);
    settle();
    `CHK("digital_offset", {8'h7F, 8'h00, 8'h01}, digital_offset)
    `CHK("dac_code", {10'h3FF, 10'h202, 10'h001}, offset_dac_code)
    wr8(8'h24, 8'h00);
    auto_black_level_comp <= 1'b0;
  endtask

  // with external clamp the new code waits for the clamp rise
  task automatic t_clamp;
    ext_clamp_sel <= 1'b1;
    wr8(8'h24, 8'h40);
    settle();
    `CHK("dac_red", 10'h001, offset_dac_code[9:0])
    @(posedge mclk);
    clamp_pulse <= 1'b1;
    settle();
    `CHK("dac_red", 10'h101, offset_dac_code[9:0])
    @(posedge mclk);
    clamp_pulse   <= 1'b0;
    ext_clamp_sel <= 1'b0;
  endtask

  // counts lock pulses after one sync transition; a pulse lasts one cycle
  task automatic lock_probe(input int i, input logic lvl, input logic [2:0] ex);
    logic [2:0] cnt;
    cnt = 3'b000;
    @(posedge mclk);
    hsync_select <= i[0];
    if (i == 0)
      first_hsync_input <= lvl;
    else
      second_hsync_input <= lvl;
    repeat (5)
    begin
      @(negedge mclk);
      if (pll_lock_pulse[i] === 1'b1)
        cnt++;
    end
    `CHK("lock_pulses", ex, cnt)
  endtask

  task automatic t_lock;
    wr8(8'h4C, 8'h00);
    lock_probe(0, 1'b1, 3'd0);
    lock_probe(0, 1'b0, 3'd1);
    lock_probe(1, 1'b1, 3'd0);
    lock_probe(1, 1'b0, 3'd1);
    wr8(8'h4C, 8'h03);
    lock_probe(0, 1'b1, 3'd1);
    lock_probe(0, 1'b0, 3'd0);
    lock_probe(1, 1'b1, 3'd1);
    lock_probe(1, 1'b0, 3'd0);
  endtask

  // clock invert pin passes only while the disable bit is clear
  task automatic t_clkinv;
    clock_invert_pin <= 1'b1;
    wr8(8'h4C, 8'h00);
    settle();
    `CHK("clkinv", 1'b1, clock_invert_eff)
    wr8(8'h4C, 8'h08);
    settle();
    `CHK("clkinv", 1'b0, clock_invert_eff)
  endtask

  // coast holds through vsync and, with no lines counted, past its end
  task automatic t_coast;
    @(posedge mclk);
    vsync <= 1'b1;
    settle();
    `CHK("coast", 1'b1, pll_coast)
    @(posedge mclk);
    vsync <= 1'b0;
    settle();
    `CHK("coast", 1'b1, pll_coast)
  endtask

  initial
  begin
    mclk = 1'b0; reset = 1'b1; ce = 1'b1; avs_read = 1'b0; avs_write = 1'b0;
    avs_address = 8'h00; avs_writedata = 32'h00000000; avs_byteenable = 4'hF;
    auto_black_level_comp = 1'b0; ext_clamp_sel = 1'b0; clamp_pulse = 1'b0;
    first_hsync_input = 1'b0; second_hsync_input = 1'b0; hsync_select = 1'b0;
    vsync = 1'b0; clock_invert_pin = 1'b0; n_errors = 0; n_checks = 0;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    t_regs();
    t_line_total();
    t_offsets();
    t_clamp();
    t_lock();
    t_clkinv();
    t_coast();
    give_verdict();
  end

  // a hang ends in the same verdict
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    give_verdict();
  end
endmodule
